// >>> verilog/mssup_defs.svh
// Purpose: constants for the motor start and stall supervisor
// Assumes: one 100 MHz clock, word-aligned AHB-Lite registers
// Notes:   offsets are byte addresses of 32-bit words
`ifndef MSSUP_DEFS_SVH
`define MSSUP_DEFS_SVH
// register byte offsets
`define MSSUP_A_CTRL       8'h00
`define MSSUP_A_START_TIME 8'h04
`define MSSUP_A_WAIT_TIME  8'h08
`define MSSUP_A_HEAT_LIM   8'h0C
`define MSSUP_A_EVT_SEL    8'h10
`define MSSUP_A_STATUS     8'h14
`define MSSUP_A_IRQ_STAT   8'h18
`define MSSUP_A_IRQ_MASK   8'h1C
`define MSSUP_A_TIME       8'h20
`define MSSUP_A_REC_SEL    8'h24
`define MSSUP_A_REC_TIME   8'h28
`define MSSUP_A_REC_INFO   8'h2C
`define MSSUP_A_REC_DUR    8'h30
`define MSSUP_A_REC_PCT    8'h34
`define MSSUP_A_REC_L1     8'h38
`define MSSUP_A_REC_L2     8'h3C
`define MSSUP_A_REC_L3     8'h40
// control field positions
`define MSSUP_B_I2T        0
`define MSSUP_B_SPD_EN     1
`define MSSUP_B_NC         2
`define MSSUP_B_STALL      3
// reset values
`define MSSUP_CTRL_RST     4'h0
`define MSSUP_STEPS_RST    20'h00008
`define MSSUP_HEAT_RST     32'h0001_0000
`define MSSUP_EVSEL_RST    14'h3FFF
// timing: clock cycles per millisecond at 100 MHz, step in ms
`define MSSUP_CLK_KHZ      100000
`define MSSUP_TICK_MS      1
`define MSSUP_STEP_MS      23'h000005
// arithmetic
`define MSSUP_PCT_FULL     40'h00_0000_0064
`define MSSUP_HEAT_SHIFT   8
`define MSSUP_EV_N         7
`endif

// >>> verilog/mssup_pkg.sv
// Purpose: shared types for the motor start and stall supervisor
// Assumes: constants come from mssup_defs.svh
// Notes:   supervision sequence and event vector types
`default_nettype none
package mssup_pkg;
    // supervision sequence
    typedef enum logic [1:0] {
        MSSUP_IDLE,
        MSSUP_TIMING,
        MSSUP_TRIPPED
    } mssup_state_t;
    // one bit per reported condition
    typedef logic [6:0] mssup_ev_t;
endpackage
`default_nettype wire

// >>> verilog/mssup_top.sv
// Purpose: motor start / locked-rotor supervision with AHB-Lite registers
// Assumes: currents and motor status come from logic on i_clock
// Notes:   speed switch pin is synchronised; records kept in a ring
// What this block does
// - settable start time limit, 5 ms steps
// - definite mode compares condition duration to limit
// - heating mode integrates current squared instead
// - speed switch use selectable, default off
// - no speed switch within wait halts start
// - speed switch polarity NO or NC
// - mode: starts only, or starts and stall
// - start output while trip is pending
// - trip only after pickup and timing met
// - blocked output when start active but blocked
// - per event ON/OFF storage selection
// - every event carries millisecond time stamp
// - ON/OFF events for seven conditions
// - keep last twelve records, overwrite oldest
// - record holds time, event, duration, usage, currents
`timescale 1ns/1ps
`default_nettype none
`include "mssup_defs.svh"
module mssup_top
    import mssup_pkg::*;
#(
    parameter int P_CYC_PER_MS = `MSSUP_CLK_KHZ * `MSSUP_TICK_MS,
    parameter int P_RECS       = 12,
    parameter int P_CUR_W      = 16
) (
    // clock and reset
    input  wire logic               i_clock,
    input  wire logic               i_sys_rst,
    // ahb-lite slave
    input  wire logic               i_hsel,
    input  wire logic [31:0]        i_haddr,
    input  wire logic [1:0]         i_htrans,
    input  wire logic               i_hwrite,
    input  wire logic [2:0]         i_hsize,
    input  wire logic               i_hready,
    input  wire logic [31:0]        i_hwdata,
    output logic      [31:0]        o_hrdata,
    output logic                    o_hreadyout,
    output logic                    o_hresp,
    // measurements and motor status
    input  wire logic [P_CUR_W-1:0] i_cur_l1,
    input  wire logic [P_CUR_W-1:0] i_cur_l2,
    input  wire logic [P_CUR_W-1:0] i_cur_l3,
    input  wire logic               i_motor_starting,
    input  wire logic               i_motor_stalled,
    input  wire logic               i_block,
    input  wire logic [2:0]         i_set_group,
    input  wire logic               i_speed_sw,
    // function outputs
    output logic                    o_start,
    output logic                    o_trip,
    output logic                    o_blocked,
    output logic                    o_irq
);
    localparam int IW = $clog2(P_RECS);

    // refuse sizes the logic cannot serve
    if (P_RECS < 2 || P_RECS > 256 || P_CUR_W < 1 || P_CUR_W > 16
        || P_CYC_PER_MS < 2) begin : g_bad
        $error("mssup_top: unsupported parameter value");
    end

    // settings and bus state
    logic [3:0]      ctrl_r;
    logic [19:0]     start_steps_r;
    logic [19:0]     wait_steps_r;
    logic [31:0]     heat_lim_r;
    logic [13:0]     ev_sel_r;
    mssup_ev_t       irq_stat_r;
    mssup_ev_t       irq_mask_r;
    logic [31:0]     time_ms_r;
    logic [IW-1:0]   rec_sel_r;
    logic            dph_r;
    logic            dwr_r;
    logic [7:0]      dadr_r;
    // supervision state
    mssup_state_t    state_r;
    logic [31:0]     cyc_r;
    logic            tick_r;
    logic            spd_meta_r;
    logic            spd_sync_r;
    logic [22:0]     dur_r;
    logic [31:0]     heat_r;
    logic            spd_seen_r;
    logic            trip_cap_r;
    logic            dt_exc_r;
    logic            hx_exc_r;
    logic            ssnr_r;
    mssup_ev_t       ev_prev_r;
    logic [13:0]     pend_r;
    logic [IW-1:0]   wr_ptr_r;
    logic [IW:0]     rec_cnt_r;
    // record memory
    logic [31:0]     rec_time_m [P_RECS];
    logic [15:0]     rec_info_m [P_RECS];
    logic [22:0]     rec_dur_m  [P_RECS];
    logic [31:0]     rec_pct_m  [P_RECS];
    logic [15:0]     rec_l1_m   [P_RECS];
    logic [15:0]     rec_l2_m   [P_RECS];
    logic [15:0]     rec_l3_m   [P_RECS];

    // lowest pending event report, 4'hF when none
    function automatic logic [3:0] mssup_first(input logic [13:0] v);
        logic [3:0] k;
        k = 4'hF;
        for (int i = 13; i >= 0; i--) begin
            if (v[i]) begin
                k = 4'(i);
            end
        end
        return k;
    endfunction

    // derived conditions
    logic            cond;
    logic            spd_act;
    logic [22:0]     lim_ms;
    logic [22:0]     wait_ms;
    logic [P_CUR_W-1:0] imax;
    logic [31:0]     sq;
    logic [32:0]     heat_sum;
    mssup_ev_t       ev_now;
    logic [13:0]     chg;
    logic [13:0]     rise_fall;
    logic [3:0]      pick;
    logic            take;
    logic            acc;
    logic            rd_stat;
    logic [39:0]     set_pct;
    logic [39:0]     cap_pct;

    assign cond    = i_motor_starting
                   | (ctrl_r[`MSSUP_B_STALL] & i_motor_stalled);
    assign spd_act = spd_sync_r ^ ctrl_r[`MSSUP_B_NC];
    assign lim_ms  = 23'(start_steps_r * `MSSUP_STEP_MS);
    assign wait_ms = 23'(wait_steps_r * `MSSUP_STEP_MS);
    assign imax    = (i_cur_l1 >= i_cur_l2 && i_cur_l1 >= i_cur_l3)
                   ? i_cur_l1 : (i_cur_l2 >= i_cur_l3 ? i_cur_l2 : i_cur_l3);
    assign sq       = (32'(imax) * 32'(imax)) >> `MSSUP_HEAT_SHIFT;
    assign heat_sum = {1'b0, heat_r} + {1'b0, sq};
    // event vector: max exceed, set exceed, no speed, start,
    // set-time trip, capacity trip, blocked
    assign ev_now  = {o_blocked, o_trip & trip_cap_r,
                      o_trip & ~trip_cap_r, o_start,
                      ssnr_r, dt_exc_r, hx_exc_r};
    assign chg       = {ev_prev_r & ~ev_now, ev_now & ~ev_prev_r};
    assign rise_fall = chg & ev_sel_r;
    assign pick    = mssup_first(pend_r);
    assign take    = (pick != 4'hF);
    assign acc     = i_hsel & i_htrans[1] & i_hready;
    assign rd_stat = dph_r & ~dwr_r & (dadr_r == `MSSUP_A_IRQ_STAT);
    assign set_pct = (lim_ms == 23'h0) ? 40'h0
                   : (40'(dur_r) * `MSSUP_PCT_FULL) / 40'(lim_ms);
    assign cap_pct = (heat_lim_r == 32'h0) ? 40'h0
                   : (40'(heat_r) * `MSSUP_PCT_FULL) / 40'(heat_lim_r);

    // speed switch pin synchroniser
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            spd_meta_r <= 1'b0;
            spd_sync_r <= 1'b0;
        end else begin
            spd_meta_r <= i_speed_sw;
            spd_sync_r <= spd_meta_r;
        end
    end

    // millisecond tick and time stamp counter
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            cyc_r     <= 32'h0;
            tick_r    <= 1'b0;
            time_ms_r <= 32'h0;
        end else begin
            tick_r <= (cyc_r == 32'(P_CYC_PER_MS - 2));
            if (cyc_r == 32'(P_CYC_PER_MS - 1)) begin
                cyc_r <= 32'h0;
            end else begin
                cyc_r <= cyc_r + 32'h1;
            end
            if (dph_r && dwr_r && dadr_r == `MSSUP_A_TIME) begin
                time_ms_r <= i_hwdata;
            end else if (tick_r) begin
                time_ms_r <= time_ms_r + 32'h1;
            end
        end
    end

    // duration and heating integrals, cleared when condition drops
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || !cond) begin
            dur_r      <= 23'h0;
            heat_r     <= 32'h0;
            spd_seen_r <= 1'b0;
        end else begin
            if (tick_r && dur_r != 23'h7FFFFF) begin
                dur_r <= dur_r + 23'h1;
            end
            if (tick_r) begin
                heat_r <= heat_sum[32] ? 32'hFFFF_FFFF
                                       : heat_sum[31:0];
            end
            if (spd_act) begin
                spd_seen_r <= 1'b1;
            end
        end
    end

    // timing comparisons
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            dt_exc_r <= 1'b0;
            hx_exc_r <= 1'b0;
            ssnr_r   <= 1'b0;
        end else begin
            dt_exc_r <= cond & ~ctrl_r[`MSSUP_B_I2T]
                      & (dur_r >= lim_ms);
            hx_exc_r <= cond & ctrl_r[`MSSUP_B_I2T]
                      & (heat_r >= heat_lim_r);
            ssnr_r   <= cond & ctrl_r[`MSSUP_B_SPD_EN] & ~spd_seen_r
                      & ~spd_act & (dur_r >= wait_ms);
        end
    end

    // supervision sequence
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state_r    <= MSSUP_IDLE;
            trip_cap_r <= 1'b0;
        end else begin
            case (state_r)
                MSSUP_IDLE: begin
                    if (cond) begin
                        state_r <= MSSUP_TIMING;
                    end
                end
                MSSUP_TIMING: begin
                    if (!cond) begin
                        state_r <= MSSUP_IDLE;
                    end else if (!i_block
                                 && (dt_exc_r || hx_exc_r || ssnr_r)) begin
                        state_r    <= MSSUP_TRIPPED;
                        trip_cap_r <= hx_exc_r;
                    end
                end
                MSSUP_TRIPPED: begin
                    if (!cond) begin
                        state_r <= MSSUP_IDLE;
                    end
                end
                default: begin
                    state_r <= MSSUP_IDLE;
                end
            endcase
        end
    end

    // function outputs
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_start   <= 1'b0;
            o_trip    <= 1'b0;
            o_blocked <= 1'b0;
        end else begin
            o_start   <= (state_r == MSSUP_TIMING) & cond;
            o_trip    <= (state_r == MSSUP_TRIPPED) & cond;
            o_blocked <= (state_r == MSSUP_TIMING) & cond
                       & i_block;
        end
    end

    // event edges, pending reports and record write pointer
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            ev_prev_r <= 7'h00;
            pend_r    <= 14'h0000;
            wr_ptr_r  <= '0;
            rec_cnt_r <= '0;
        end else begin
            ev_prev_r <= ev_now;
            // a new edge wins over the report being taken
            pend_r <= (pend_r & ~(take ? (14'h0001 << pick) : 14'h0000))
                    | rise_fall;
            if (take) begin
                wr_ptr_r <= (wr_ptr_r == IW'(P_RECS - 1))
                          ? '0 : wr_ptr_r + IW'(1);
                if (rec_cnt_r != (IW+1)'(P_RECS)) begin
                    rec_cnt_r <= rec_cnt_r + (IW+1)'(1);
                end
            end
        end
    end

    // record ring, oldest entry overwritten
    always_ff @(posedge i_clock) begin
        if (take) begin
            rec_time_m[wr_ptr_r] <= time_ms_r;
            rec_info_m[wr_ptr_r] <= {5'h00, i_set_group, 4'h0,
                                     pick};
            rec_dur_m[wr_ptr_r]  <= dur_r;
            rec_pct_m[wr_ptr_r]  <= {cap_pct[15:0], set_pct[15:0]};
            rec_l1_m[wr_ptr_r]   <= 16'(i_cur_l1);
            rec_l2_m[wr_ptr_r]   <= 16'(i_cur_l2);
            rec_l3_m[wr_ptr_r]   <= 16'(i_cur_l3);
        end
    end

    // sticky interrupt status, cleared by read, set wins
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            irq_stat_r <= 7'h00;
            o_irq      <= 1'b0;
        end else begin
            irq_stat_r <= (rd_stat ? 7'h00 : irq_stat_r)
                        | chg[6:0] | chg[13:7];
            o_irq      <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ahb-lite phase tracking, one wait state per transfer
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            dph_r       <= 1'b0;
            dwr_r       <= 1'b0;
            dadr_r      <= 8'h00;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else begin
            o_hresp <= 1'b0;
            if (dph_r) begin
                dph_r       <= 1'b0;
                o_hreadyout <= 1'b1;
            end else if (acc) begin
                dph_r       <= 1'b1;
                dwr_r       <= i_hwrite;
                dadr_r      <= i_haddr[7:0];
                o_hreadyout <= 1'b0;
            end
        end
    end

    // register writes
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            ctrl_r        <= `MSSUP_CTRL_RST;
            start_steps_r <= `MSSUP_STEPS_RST;
            wait_steps_r  <= `MSSUP_STEPS_RST;
            heat_lim_r    <= `MSSUP_HEAT_RST;
            ev_sel_r      <= `MSSUP_EVSEL_RST;
            irq_mask_r    <= 7'h00;
            rec_sel_r     <= '0;
        end else if (dph_r && dwr_r) begin
            if (dadr_r == `MSSUP_A_CTRL) begin
                ctrl_r <= i_hwdata[3:0];
            end else if (dadr_r == `MSSUP_A_START_TIME) begin
                start_steps_r <= i_hwdata[19:0];
            end else if (dadr_r == `MSSUP_A_WAIT_TIME) begin
                wait_steps_r <= i_hwdata[19:0];
            end else if (dadr_r == `MSSUP_A_HEAT_LIM) begin
                heat_lim_r <= i_hwdata;
            end else if (dadr_r == `MSSUP_A_EVT_SEL) begin
                ev_sel_r <= i_hwdata[13:0];
            end else if (dadr_r == `MSSUP_A_IRQ_MASK) begin
                irq_mask_r <= i_hwdata[6:0];
            end else if (dadr_r == `MSSUP_A_REC_SEL) begin
                rec_sel_r <= (i_hwdata[IW-1:0] >= IW'(P_RECS))
                           ? '0 : i_hwdata[IW-1:0];
            end
        end
    end

    // register reads, unmapped words read zero
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_hrdata <= 32'h0;
        end else if (acc && !dph_r && !i_hwrite) begin
            o_hrdata <= 32'h0;
        end else if (dph_r && !dwr_r) begin
            if (dadr_r == `MSSUP_A_CTRL) begin
                o_hrdata <= {28'h0, ctrl_r};
            end else if (dadr_r == `MSSUP_A_START_TIME) begin
                o_hrdata <= {12'h0, start_steps_r};
            end else if (dadr_r == `MSSUP_A_WAIT_TIME) begin
                o_hrdata <= {12'h0, wait_steps_r};
            end else if (dadr_r == `MSSUP_A_HEAT_LIM) begin
                o_hrdata <= heat_lim_r;
            end else if (dadr_r == `MSSUP_A_EVT_SEL) begin
                o_hrdata <= {18'h0, ev_sel_r};
            end else if (dadr_r == `MSSUP_A_STATUS) begin
                o_hrdata <= {7'h0, 9'(rec_cnt_r), 8'h0, 1'b0, ev_now};
            end else if (dadr_r == `MSSUP_A_IRQ_STAT) begin
                o_hrdata <= {25'h0, irq_stat_r};
            end else if (dadr_r == `MSSUP_A_IRQ_MASK) begin
                o_hrdata <= {25'h0, irq_mask_r};
            end else if (dadr_r == `MSSUP_A_TIME) begin
                o_hrdata <= time_ms_r;
            end else if (dadr_r == `MSSUP_A_REC_SEL) begin
                o_hrdata <= 32'(rec_sel_r);
            end else if (dadr_r == `MSSUP_A_REC_TIME) begin
                o_hrdata <= rec_time_m[rec_sel_r];
            end else if (dadr_r == `MSSUP_A_REC_INFO) begin
                o_hrdata <= {16'h0, rec_info_m[rec_sel_r]};
            end else if (dadr_r == `MSSUP_A_REC_DUR) begin
                o_hrdata <= {9'h0, rec_dur_m[rec_sel_r]};
            end else if (dadr_r == `MSSUP_A_REC_PCT) begin
                o_hrdata <= rec_pct_m[rec_sel_r];
            end else if (dadr_r == `MSSUP_A_REC_L1) begin
                o_hrdata <= {16'h0, rec_l1_m[rec_sel_r]};
            end else if (dadr_r == `MSSUP_A_REC_L2) begin
                o_hrdata <= {16'h0, rec_l2_m[rec_sel_r]};
            end else if (dadr_r == `MSSUP_A_REC_L3) begin
                o_hrdata <= {16'h0, rec_l3_m[rec_sel_r]};
            end else begin
                o_hrdata <= 32'h0;
            end
        end
    end

    // unused bus inputs are accepted without effect
    logic unused_ok;
    assign unused_ok = ^{i_hsize, i_haddr[31:8], i_htrans[0]};
endmodule
`default_nettype wire

// >>> dv/mssup_assertions.sv
// Purpose: port checks for the start and stall supervisor
// Assumes: one clock, synchronous active-high reset
// Notes:   bound onto mssup_top after the checker
`timescale 1ns/1ps
`default_nettype none
module mssup_chk (
    // clock, reset and bus
    input wire logic       i_clock,
    input wire logic       i_sys_rst,
    input wire logic       i_hsel,
    input wire logic [1:0] i_htrans,
    input wire logic       i_hready,
    input wire logic       o_hreadyout,
    input wire logic       o_hresp,
    // motor side
    input wire logic       i_motor_starting,
    input wire logic       i_motor_stalled,
    input wire logic       i_block,
    input wire logic       o_start,
    input wire logic       o_trip,
    input wire logic       o_blocked,
    input wire logic       o_irq
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    // any condition the block may supervise
    wire logic cond = i_motor_starting | i_motor_stalled;
    // one wait state, then ready again
    sequence s_dip;
        !o_hreadyout ##1 o_hreadyout;
    endsequence
    a_bus_okay: assert property (!o_hresp)
        else $error("bus response not okay");
    a_ready_dip: assert property ((i_hsel && i_htrans[1] && i_hready) |=> s_dip)
        else $error("ready did not dip for one cycle");
    a_reset_quiet: assert property (disable iff (1'b0)
        i_sys_rst |=> !o_start && !o_trip && !o_blocked && !o_irq && o_hreadyout)
        else $error("outputs not idle after reset");
    a_start_cause: assert property ($rose(o_start) |-> $past(cond, 2))
        else $error("start rose without a condition");
    a_start_drop: assert property ((o_start && !cond) |-> ##[1:3] !o_start)
        else $error("start held after condition ended");
    a_trip_after_start: assert property ($rose(o_trip) |-> $past(o_start))
        else $error("trip without prior start");
    a_trip_excl: assert property (!(o_start && o_trip))
        else $error("start and trip both high");
    a_trip_clear: assert property ((o_trip && !cond) |-> ##[1:3] !o_trip)
        else $error("trip held after condition ended");
    a_blocked_src: assert property (o_blocked |->
        $past(i_block) && ($past(o_start) || o_start))
        else $error("blocked without start and block");
endmodule
bind mssup_top mssup_chk mssup_chk_inst (
    .i_clock, .i_sys_rst, .i_hsel, .i_htrans, .i_hready, .o_hreadyout,
    .o_hresp, .i_motor_starting, .i_motor_stalled, .i_block, .o_start,
    .o_trip, .o_blocked, .o_irq
);
`default_nettype wire

// >>> dv/mssup_feeder.sv
// Purpose: model of the motor feeder and its speed contact
// Assumes: starter command and rotor speed come from the bench
// Notes:   outputs change right after the clock edge
`timescale 1ns/1ps
`default_nettype none
module mssup_feeder #(
    parameter logic [15:0] P_AMPS = 16'h0100
) (
    // commands
    input  wire logic        i_clock,
    input  wire logic        i_run,
    input  wire logic        i_spin,
    input  wire logic        i_nc,
    // feeder signals
    output var  logic [15:0] o_cur_l1 = 16'h0000,
    output var  logic [15:0] o_cur_l2 = 16'h0000,
    output var  logic [15:0] o_cur_l3 = 16'h0000,
    output var  logic        o_starting = 1'b0,
    output var  logic        o_speed_sw = 1'b0
);
    // start current flows while the starter is closed
    always @(posedge i_clock) begin
        o_starting <= i_run;
        o_cur_l1   <= i_run ? P_AMPS : 16'h0000;
        o_cur_l2   <= i_run ? P_AMPS - 16'h0010 : 16'h0000;
        o_cur_l3   <= i_run ? P_AMPS - 16'h0020 : 16'h0000;
    end
    // contact makes at speed if open at rest, breaks if closed at rest
    always @(posedge i_clock) begin
        o_speed_sw <= i_spin ^ i_nc;
    end
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Purpose: self-checking bench for the start and stall supervisor
// Assumes: one millisecond scaled down to ten clocks
// Notes:   registers reached by an ahb-lite master task
`timescale 1ns/1ps
`default_nettype none
`include "mssup_defs.svh"
module tb;
    logic        i_clock = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, q;
    logic        hready, hresp, starting, spd;
    logic        run = 1'b0, stall = 1'b0, blk = 1'b0, spin = 1'b0, nc = 1'b0;
    logic [15:0] c1, c2, c3;
    logic        o_start, o_trip, o_blocked, o_irq;
    int          k, failures = 0, compares = 0;
    // clock and reset
    always #5 i_clock = ~i_clock;
    mssup_feeder mssup_feeder_inst (.i_clock, .i_run(run), .i_spin(spin),
        .i_nc(nc), .o_cur_l1(c1), .o_cur_l2(c2), .o_cur_l3(c3),
        .o_starting(starting), .o_speed_sw(spd));
    mssup_top #(.P_CYC_PER_MS(10)) mssup_top_inst (.i_clock, .i_sys_rst,
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hready(hready), .i_hwdata(hwdata),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_cur_l1(c1), .i_cur_l2(c2), .i_cur_l3(c3),
        .i_motor_starting(starting), .i_motor_stalled(stall), .i_block(blk),
        .i_set_group(3'h2), .i_speed_sw(spd), .o_start, .o_trip, .o_blocked,
        .o_irq);
    // compare one value
    task automatic chk(input string m, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // one single-word bus transfer
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        do @(posedge i_clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge i_clock); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    // count clocks until trip or start shows, at most n
    task automatic cyc_to(input bit trip, input int n);
        k = 0;
        while (((trip ? o_trip : o_start) !== 1'b1) && k < n) begin
            @(posedge i_clock);
            k++;
        end
    endtask
    task automatic idle;
        run <= 1'b0;
        stall <= 1'b0;
        spin <= 1'b0;
        blk <= 1'b0;
        repeat (20) @(posedge i_clock);
    endtask
    // reset values and an unmapped word
    task automatic t_defaults;
        logic [7:0]  a[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C, 8'h80};
        logic [31:0] e[7] = '{32'h0, 32'h8, 32'h8, 32'h10000, 32'h3FFF, 32'h0,
                              32'h0};
        bus(1'b1, 8'h80, 32'hFFFFFFFF);
        for (int i = 0; i < 7; i++) begin
            rd(a[i]);
            chk("reset value", q, e[i]);
        end
    endtask
    // definite time start that runs into the limit
    task automatic t_definite;
        bus(1'b1, `MSSUP_A_START_TIME, 32'h2);
        bus(1'b1, `MSSUP_A_IRQ_MASK, 32'h8);
        rd(`MSSUP_A_IRQ_STAT);
        run <= 1'b1;
        cyc_to(1'b0, 8);
        chk("start delay", 32'(k < 5), 32'h1);
        repeat (4) @(posedge i_clock);
        chk("irq on start", {31'h0, o_irq}, 32'h1);
        cyc_to(1'b1, 200);
        chk("trip time", 32'(k > 80 && k < 110), 32'h1);
        chk("start off", {31'h0, o_start}, 32'h0);
        rd(`MSSUP_A_STATUS);
        chk("live events", q & 32'h18, 32'h10);
        rd(`MSSUP_A_IRQ_STAT);
        repeat (3) @(posedge i_clock);
        chk("irq cleared", {31'h0, o_irq}, 32'h0);
        idle();
        chk("trip off", {31'h0, o_trip}, 32'h0);
    endtask
    // short start with storage switched off
    task automatic t_early;
        logic [31:0] n0;
        bus(1'b1, `MSSUP_A_EVT_SEL, 32'h0);
        rd(`MSSUP_A_STATUS);
        n0 = q;
        run <= 1'b1;
        repeat (30) @(posedge i_clock);
        run <= 1'b0;
        repeat (150) @(posedge i_clock);
        chk("no trip", {30'h0, o_start, o_trip}, 32'h0);
        rd(`MSSUP_A_STATUS);
        chk("nothing stored", q & 32'h1FF0000, n0 & 32'h1FF0000);
        bus(1'b1, `MSSUP_A_EVT_SEL, 32'h3FFF);
    endtask
    // blocked start never trips
    task automatic t_block;
        blk <= 1'b1;
        run <= 1'b1;
        repeat (6) @(posedge i_clock);
        chk("blocked", {31'h0, o_blocked}, 32'h1);
        repeat (150) @(posedge i_clock);
        chk("no trip", {31'h0, o_trip}, 32'h0);
        idle();
    endtask
    // speed contact, closed at rest, missing then present
    task automatic t_speed;
        nc <= 1'b1;
        bus(1'b1, `MSSUP_A_START_TIME, 32'h8);
        bus(1'b1, `MSSUP_A_WAIT_TIME, 32'h1);
        bus(1'b1, `MSSUP_A_CTRL, 32'h6);
        run <= 1'b1;
        cyc_to(1'b1, 150);
        chk("miss trip", 32'(k > 35 && k < 80), 32'h1);
        rd(`MSSUP_A_STATUS);
        chk("miss event", q & 32'h14, 32'h14);
        idle();
        run <= 1'b1;
        spin <= 1'b1;
        cyc_to(1'b1, 150);
        chk("speed seen", {31'h0, o_trip}, 32'h0);
        idle();
    endtask
    // stall supervised only in the wider mode
    task automatic t_stall;
        bus(1'b1, `MSSUP_A_CTRL, 32'h0);
        stall <= 1'b1;
        repeat (6) @(posedge i_clock);
        chk("stall ignored", {31'h0, o_start}, 32'h0);
        bus(1'b1, `MSSUP_A_CTRL, 32'h8);
        repeat (4) @(posedge i_clock);
        chk("stall seen", {31'h0, o_start}, 32'h1);
        idle();
    endtask
    // heating mode trips well before the time limit
    task automatic t_heat;
        bus(1'b1, `MSSUP_A_CTRL, 32'h1);
        bus(1'b1, `MSSUP_A_HEAT_LIM, 32'h400);
        run <= 1'b1;
        cyc_to(1'b1, 300);
        chk("heat trip", 32'(k > 20 && k < 100), 32'h1);
        rd(`MSSUP_A_STATUS);
        chk("cap event", q & 32'h20, 32'h20);
        idle();
        rd(`MSSUP_A_STATUS);
        chk("ring full", q & 32'h1FF0000, 32'hC0000);
        rd(`MSSUP_A_REC_INFO);
        chk("group", q & 32'h700, 32'h200);
    endtask
    task automatic close_out;
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        t_defaults();
        t_definite();
        t_early();
        t_block();
        t_speed();
        t_stall();
        t_heat();
        close_out();
    end
    // watchdog well past the expected thousand or so clocks
    initial begin
        repeat (20000) @(posedge i_clock);
        failures++;
        close_out();
    end
endmodule
`default_nettype wire
